// ---- verilog/core_mem_pkg.sv ----
// Shared constants and types for the core memory organisation block
package core_mem_pkg;

// ==========================================================
// Program space
localparam int PC_W = 15;
localparam int PROG_WORDS_SMALL = 8192;
localparam int PROG_WORDS_LARGE = 16384;
localparam int HE_WORDS = 128;
localparam int STACK_DEPTH = 16;
localparam logic [14:0] RESET_VEC = 15'h0000;
localparam logic [14:0] INT_VEC = 15'h0004;

// ==========================================================
// Data space
localparam int BANK_W = 5;
localparam int OFS_W = 7;
localparam int GPR_PER_BANK = 80;
localparam int COM_BYTES = 16;
localparam logic [6:0] OFS_IND0 = 7'h00;
localparam logic [6:0] OFS_IND1 = 7'h01;
localparam logic [6:0] OFS_PCL = 7'h02;
localparam logic [6:0] OFS_FLAGS = 7'h03;
localparam logic [6:0] OFS_P0L = 7'h04;
localparam logic [6:0] OFS_P0H = 7'h05;
localparam logic [6:0] OFS_P1L = 7'h06;
localparam logic [6:0] OFS_P1H = 7'h07;
localparam logic [6:0] OFS_BSR = 7'h08;
localparam logic [6:0] OFS_WORKING_REGISTER = 7'h09;
localparam logic [6:0] OFS_PROG_COUNTER_LATCH_HIGH = 7'h0A;
localparam logic [6:0] OFS_INTCTL = 7'h0B;
localparam logic [6:0] SFR_LO = 7'h0C;
localparam logic [6:0] SFR_HI = 7'h1F;
localparam logic [6:0] GPR_LO = 7'h20;
localparam logic [6:0] GPR_HI = 7'h6F;
localparam logic [6:0] COM_LO = 7'h70;
localparam int PTR_PROG_BIT = 15;
localparam logic [2:0] LIN_TAG = 3'h1;

// ==========================================================
// Flag register layout and reset values
localparam int ST_C = 0;
localparam int ST_DC = 1;
localparam int ST_Z = 2;
localparam int ST_PD = 3;
localparam int ST_TO = 4;
localparam logic [7:0] FLAGS_RST = 8'h18;
localparam logic [7:0] BYTE_RST = 8'h00;
localparam logic [15:0] PTR_RST = 16'h0000;

// ==========================================================
// Types
typedef enum logic [2:0] {
    PC_HOLD = 3'b000, PC_INC = 3'b001, PC_JUMP = 3'b010, PC_CALL = 3'b011,
    PC_RET = 3'b100, PC_INT = 3'b101, PC_RETFIE = 3'b110
} pc_op_e;
typedef enum logic [1:0] {
    SRC_DIRECT = 2'b00, SRC_PTR0 = 2'b01, SRC_PTR1 = 2'b10
} src_e;
typedef enum logic [1:0] {ALU_NONE = 2'b00, ALU_ADD = 2'b01, ALU_SUB = 2'b10, ALU_LOGIC = 2'b11} alu_op_e;
typedef enum logic [1:0] {PD_IDLE = 2'b00, PD_PROG = 2'b01, PD_SFR = 2'b10} pend_e;
typedef struct packed {logic rd; logic wr; src_e src; logic [6:0] ofs; logic [7:0] wdata;} data_req_s;
typedef struct packed {alu_op_e op; logic [7:0] a; logic [7:0] b;} alu_req_s;
typedef struct packed {logic valid; logic [7:0] rdata;} data_rsp_s;
typedef struct packed {logic sel; logic wr; logic [11:0] addr; logic [7:0] wdata;} sfr_bus_s;

endpackage : core_mem_pkg

// ---- verilog/core_mem_org.sv ----
// Core memory organisation: program counter, stack, banked data memory, flags
`timescale 1ns/1ps
module core_mem_org
    import core_mem_pkg::*;
#(
    parameter int PROG_WORDS = PROG_WORDS_SMALL,
    parameter int GPR_BANKS  = 8
) (
    input  logic             clk,
    input  logic             rstn,
    input  logic             ce,
    input  data_req_s        dreq,
    input  alu_req_s         alu,
    input  pc_op_e           pc_op,
    input  logic [PC_W-1:0]  pc_target,
    input  logic             wdt_clear_op,
    input  logic             sleep_op,
    input  logic             wdt_timeout,
    input  logic             stack_reset_en,
    input  logic [1:0]       stack_flag_clr,
    input  logic [13:0]      prog_word,
    input  logic [7:0]       sfr_rdata,
    output logic [PC_W-1:0]  pc_r,
    output data_rsp_s        rsp_r,
    output logic             stall_r,
    output logic [7:0]       working_reg_r,
    output logic [7:0]       alu_flags_r,
    output logic [PC_W-1:0]  prog_daddr_r,
    output logic             prog_drd_r,
    output logic             he_region_r,
    output sfr_bus_s         sfr_r,
    output logic             stack_overrun_flag_r,
    output logic             stack_underrun_flag_r,
    output logic             soft_reset_r
);

// ==========================================================
// Sizes
localparam int GPR_N = GPR_BANKS * GPR_PER_BANK;
localparam int GI_W = $clog2(GPR_N);
localparam logic [PC_W-1:0] PC_MASK = PC_W'(PROG_WORDS - 1);
localparam logic [PC_W-1:0] HE_BASE = PC_W'(PROG_WORDS - HE_WORDS);
localparam logic [12:0] LIN_N = 13'(GPR_N);
localparam logic [5:0] GBANKS = 6'(GPR_BANKS);
localparam logic [4:0] SP_FULL = 5'(STACK_DEPTH);

// ==========================================================
// State
logic [15:0] fsr0_r;
logic [15:0] fsr1_r;
logic [4:0]  bsr_r;
logic [6:0]  prog_counter_latch_high_r;
logic [7:0]  intctl_r;
logic [4:0]  sp_r;
logic [7:0]  sh_flags_r;
logic [7:0]  sh_w_r;
logic [4:0]  sh_bsr_r;
logic [6:0]  sh_prog_counter_latch_high_r;
logic [15:0] sh_fsr0_r;
logic [15:0] sh_fsr1_r;
pend_e       pend_r;
logic [PC_W-1:0] stk_mem [STACK_DEPTH];
logic [7:0]  gpr_mem [GPR_N];
logic [7:0]  com_mem [COM_BYTES];

logic [15:0] fsr0_nxt;
logic [15:0] fsr1_nxt;
logic [4:0]  bsr_nxt;
logic [6:0]  prog_counter_latch_high_nxt;
logic [7:0]  intctl_nxt;
logic [7:0]  w_nxt;
logic [7:0]  flags_nxt;
logic [PC_W-1:0] pc_nxt;

// ==========================================================
// Address decode
wire idle    = pend_r == PD_IDLE;
wire go      = ce & idle & (dreq.rd | dreq.wr);
wire rd_go   = go & dreq.rd;
wire wr_go   = go & dreq.wr;
wire dir     = dreq.src == SRC_DIRECT;
// A direct access to an indirect port follows that port's pointer
wire ind0    = dreq.src == SRC_PTR0 | (dir & dreq.ofs == OFS_IND0);
wire ind1    = dreq.src == SRC_PTR1 | (dir & dreq.ofs == OFS_IND1);
wire is_ind  = ind0 | ind1;
wire [15:0] ptr = ind1 ? fsr1_r : fsr0_r;
wire prog_sel = is_ind & ptr[PTR_PROG_BIT];
wire lin_sel = is_ind & ptr[15:13] == LIN_TAG;
wire bnk_sel = ~is_ind | ptr[15:12] == 4'h0;
wire [11:0] daddr = is_ind ? ptr[11:0] : {bsr_r, dreq.ofs};
wire [4:0] bank = daddr[11:7];
wire [6:0] ofs = daddr[6:0];
// A pointer aimed at an indirect port reads zero, avoiding recursion
wire core_hit = bnk_sel & ofs < SFR_LO & ~(is_ind & ofs <= OFS_IND1);
wire sfr_hit = bnk_sel & ofs >= SFR_LO & ofs <= SFR_HI;
wire com_hit = bnk_sel & ofs >= COM_LO;
wire gb_hit = bnk_sel & ofs >= GPR_LO & ofs <= GPR_HI & {1'b0, bank} < GBANKS;
wire lin_hit = lin_sel & ptr[12:0] < LIN_N;
wire gpr_hit = gb_hit | lin_hit;
wire [GI_W-1:0] gb_idx = GI_W'(bank * GPR_PER_BANK) + GI_W'(ofs - GPR_LO);
wire [GI_W-1:0] gpr_idx = lin_sel ? GI_W'(ptr[12:0]) : gb_idx;
wire [3:0] com_idx = ofs[3:0];
wire core_wr = wr_go & core_hit;
wire pcl_wr = core_wr & ofs == OFS_PCL;
wire flags_wr = core_wr & ofs == OFS_FLAGS;
wire unimpl = ~core_hit & ~sfr_hit & ~gpr_hit & ~com_hit;

function automatic logic [7:0] core_read(input logic [6:0] o, input logic [7:0] prog_counter_low);
    case (o)
        OFS_PCL:    core_read = prog_counter_low;
        OFS_FLAGS:  core_read = alu_flags_r;
        OFS_P0L:    core_read = fsr0_r[7:0];
        OFS_P0H:    core_read = fsr0_r[15:8];
        OFS_P1L:    core_read = fsr1_r[7:0];
        OFS_P1H:    core_read = fsr1_r[15:8];
        OFS_BSR:    core_read = {3'h0, bsr_r};
        OFS_WORKING_REGISTER:   core_read = working_reg_r;
        OFS_PROG_COUNTER_LATCH_HIGH: core_read = {1'b0, prog_counter_latch_high_r};
        OFS_INTCTL: core_read = intctl_r;
        default:    core_read = BYTE_RST;
    endcase
endfunction : core_read

// The function reads registers that are not its arguments, so a plain assign would go stale
logic [7:0] core_rd;
always_comb begin
    core_rd = core_read(ofs, pc_r[7:0]);
end
wire [7:0] rd_val = core_hit ? core_rd :
                    gpr_hit  ? gpr_mem[gpr_idx] :
                    com_hit  ? com_mem[com_idx] : BYTE_RST;

// ==========================================================
// Arithmetic flags: subtraction adds the inverted operand plus one
wire sub = alu.op == ALU_SUB;
wire arith = alu.op == ALU_ADD | sub;
wire [7:0] opb = sub ? ~alu.b : alu.b;
wire [8:0] sum = {1'b0, alu.a} + {1'b0, opb} + {8'h00, sub};
wire [4:0] nib = {1'b0, alu.a[3:0]} + {1'b0, opb[3:0]} + {4'h0, sub};
wire [7:0] res = arith ? sum[7:0] : alu.b;
wire upd_z = ce & alu.op != ALU_NONE;
wire upd_c = ce & arith;

// ==========================================================
// Stack
wire push = ce & (pc_op == PC_CALL | pc_op == PC_INT);
wire pop = ce & (pc_op == PC_RET | pc_op == PC_RETFIE);
wire ovf = push & sp_r == SP_FULL;
wire unf = pop & sp_r == 5'h00;
wire [3:0] top_idx = 4'(sp_r - 5'h01);
wire [PC_W-1:0] top = unf ? RESET_VEC : stk_mem[top_idx];
wire [PC_W-1:0] ret_inc = (pc_r + 15'h0001) & PC_MASK;
wire [PC_W-1:0] push_val = pc_op == PC_INT ? pc_r : ret_inc;
wire save = ce & pc_op == PC_INT;
wire restore = ce & pc_op == PC_RETFIE;

// ==========================================================
// Program counter
always_comb begin
    case (pc_op)
        PC_INC:    pc_nxt = ret_inc;
        PC_JUMP,
        PC_CALL:   pc_nxt = pc_target;
        PC_RET,
        PC_RETFIE: pc_nxt = top;
        PC_INT:    pc_nxt = INT_VEC;
        default:   pc_nxt = pc_r;
    endcase
    if (pcl_wr) begin
        pc_nxt = {prog_counter_latch_high_r, dreq.wdata};
    end
    pc_nxt = pc_nxt & PC_MASK;
end

// ==========================================================
// Core register next values
always_comb begin
    fsr0_nxt = fsr0_r;
    fsr1_nxt = fsr1_r;
    bsr_nxt = bsr_r;
    prog_counter_latch_high_nxt = prog_counter_latch_high_r;
    intctl_nxt = intctl_r;
    w_nxt = working_reg_r;
    flags_nxt = alu_flags_r;
    if (core_wr) begin
        case (ofs)
            OFS_P0L:    fsr0_nxt[7:0] = dreq.wdata;
            OFS_P0H:    fsr0_nxt[15:8] = dreq.wdata;
            OFS_P1L:    fsr1_nxt[7:0] = dreq.wdata;
            OFS_P1H:    fsr1_nxt[15:8] = dreq.wdata;
            OFS_BSR:    bsr_nxt = dreq.wdata[4:0];
            OFS_WORKING_REGISTER:   w_nxt = dreq.wdata;
            OFS_PROG_COUNTER_LATCH_HIGH: prog_counter_latch_high_nxt = dreq.wdata[6:0];
            OFS_INTCTL: intctl_nxt = dreq.wdata;
            default:    w_nxt = working_reg_r;
        endcase
    end
    // Only the three result bits take a write; reset-cause bits never do
    if (flags_wr & ~upd_z) begin
        flags_nxt[ST_Z] = dreq.wdata[ST_Z];
    end
    if (flags_wr & ~upd_c) begin
        flags_nxt[ST_DC] = dreq.wdata[ST_DC];
        flags_nxt[ST_C] = dreq.wdata[ST_C];
    end
    if (upd_z) begin
        flags_nxt[ST_Z] = res == 8'h00;
    end
    if (upd_c) begin
        flags_nxt[ST_DC] = nib[4];
        flags_nxt[ST_C] = sum[8];
    end
    if (wdt_timeout) begin
        flags_nxt[ST_TO] = 1'b0;
    end
    if (wdt_clear_op | sleep_op) begin
        flags_nxt[ST_TO] = 1'b1;
    end
    if (sleep_op) begin
        flags_nxt[ST_PD] = 1'b0;
    end
    if (wdt_clear_op) begin
        flags_nxt[ST_PD] = 1'b1;
    end
    if (restore) begin
        flags_nxt[ST_Z:ST_C] = sh_flags_r[ST_Z:ST_C];
        w_nxt = sh_w_r;
        bsr_nxt = sh_bsr_r;
        prog_counter_latch_high_nxt = sh_prog_counter_latch_high_r;
        fsr0_nxt = sh_fsr0_r;
        fsr1_nxt = sh_fsr1_r;
    end
    flags_nxt[7:5] = 3'h0;
end

// ==========================================================
// Registers
always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        pc_r <= RESET_VEC;
        fsr0_r <= PTR_RST;
        fsr1_r <= PTR_RST;
        bsr_r <= 5'h00;
        prog_counter_latch_high_r <= 7'h00;
        intctl_r <= BYTE_RST;
        working_reg_r <= BYTE_RST;
        alu_flags_r <= FLAGS_RST;
    end else if (ce) begin
        pc_r <= pc_nxt;
        fsr0_r <= fsr0_nxt;
        fsr1_r <= fsr1_nxt;
        bsr_r <= bsr_nxt;
        prog_counter_latch_high_r <= prog_counter_latch_high_nxt;
        intctl_r <= intctl_nxt;
        working_reg_r <= w_nxt;
        alu_flags_r <= flags_nxt;
    end
end

always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        sh_flags_r <= BYTE_RST;
        sh_w_r <= BYTE_RST;
        sh_bsr_r <= 5'h00;
        sh_prog_counter_latch_high_r <= 7'h00;
        sh_fsr0_r <= PTR_RST;
        sh_fsr1_r <= PTR_RST;
    end else if (save) begin
        sh_flags_r <= alu_flags_r;
        sh_w_r <= working_reg_r;
        sh_bsr_r <= bsr_r;
        sh_prog_counter_latch_high_r <= prog_counter_latch_high_r;
        sh_fsr0_r <= fsr0_r;
        sh_fsr1_r <= fsr1_r;
    end
end

// Flags are sticky; a new event in the clear cycle still sets them
always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        sp_r <= 5'h00;
        stack_overrun_flag_r <= 1'b0;
        stack_underrun_flag_r <= 1'b0;
        soft_reset_r <= 1'b0;
    end else if (ce) begin
        if (push & ~ovf) begin
            sp_r <= sp_r + 5'h01;
        end else if (pop & ~unf) begin
            sp_r <= sp_r - 5'h01;
        end
        stack_overrun_flag_r <= ovf | (stack_overrun_flag_r & ~stack_flag_clr[0]);
        stack_underrun_flag_r <= unf | (stack_underrun_flag_r & ~stack_flag_clr[1]);
        soft_reset_r <= stack_reset_en & (ovf | unf);
    end
end

// Memories carry no reset; contents are undefined after power-up
always_ff @(posedge clk) begin
    if (push & ~ovf) begin
        stk_mem[sp_r[3:0]] <= push_val;
    end
    if (wr_go & gpr_hit) begin
        gpr_mem[gpr_idx] <= dreq.wdata;
    end
    if (wr_go & com_hit) begin
        com_mem[com_idx] <= dreq.wdata;
    end
end

// ==========================================================
// Access sequencing; program and peripheral reads take a second cycle
always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        pend_r <= PD_IDLE;
        rsp_r <= '0;
        stall_r <= 1'b0;
        prog_daddr_r <= RESET_VEC;
        prog_drd_r <= 1'b0;
        he_region_r <= 1'b0;
        sfr_r <= '0;
    end else if (ce) begin
        rsp_r.valid <= 1'b0;
        prog_drd_r <= 1'b0;
        sfr_r.sel <= 1'b0;
        case (pend_r)
            PD_IDLE: begin
                if (rd_go & prog_sel) begin
                    prog_daddr_r <= ptr[14:0] & PC_MASK;
                    prog_drd_r <= 1'b1;
                    he_region_r <= (ptr[14:0] & PC_MASK) >= HE_BASE;
                    stall_r <= 1'b1;
                    pend_r <= PD_PROG;
                end else if (go & sfr_hit) begin
                    sfr_r <= '{1'b1, dreq.wr, daddr, dreq.wdata};
                    stall_r <= dreq.rd;
                    pend_r <= dreq.rd ? PD_SFR : PD_IDLE;
                end else if (rd_go) begin
                    rsp_r <= '{1'b1, rd_val};
                end
            end
            PD_PROG: begin
                rsp_r <= '{1'b1, prog_word[7:0]};
                stall_r <= 1'b0;
                pend_r <= PD_IDLE;
            end
            PD_SFR: begin
                rsp_r <= '{1'b1, sfr_rdata};
                stall_r <= 1'b0;
                pend_r <= PD_IDLE;
            end
            default: begin
                stall_r <= 1'b0;
                pend_r <= PD_IDLE;
            end
        endcase
    end
end

// ==========================================================
// Checks
default clocking cb @(posedge clk); endclocking
default disable iff (!rstn || !ce);

sequence s_prog_rd;
    rd_go && prog_sel;
endsequence
sequence s_prog_ans;
    stall_r && !rsp_r.valid ##1 rsp_r.valid && !stall_r;
endsequence
property p_prog_extra;
    s_prog_rd |=> s_prog_ans;
endproperty
a_prog_extra: assert property (p_prog_extra) else $error("prog read timing");
property p_prog_nowrite;
    wr_go && prog_sel && !dreq.rd |=> !prog_drd_r && !sfr_r.sel && !stall_r;
endproperty
a_prog_nowrite: assert property (p_prog_nowrite) else $error("prog write acted");
property p_int_vec;
    pc_op == PC_INT && !pcl_wr |=> pc_r == INT_VEC;
endproperty
a_int_vec: assert property (p_int_vec) else $error("bad interrupt vector");
property p_wrap;
    (pc_r & ~PC_MASK) == 15'h0000 && (prog_daddr_r & ~PC_MASK) == 15'h0000;
endproperty
a_wrap: assert property (p_wrap) else $error("address beyond implemented size");
property p_unimpl;
    rd_go && !prog_sel && unimpl |=> rsp_r.valid && rsp_r.rdata == 8'h00;
endproperty
a_unimpl: assert property (p_unimpl) else $error("unimplemented read nonzero");
property p_mask;
    flags_wr && upd_z && !restore |=> alu_flags_r[ST_Z] == ($past(res) == 8'h00);
endproperty
a_mask: assert property (p_mask) else $error("zero flag not masked");
property p_upper;
    alu_flags_r[7:5] == 3'h0;
endproperty
a_upper: assert property (p_upper) else $error("upper flag bits set");
property p_expiry;
    wdt_timeout && !wdt_clear_op && !sleep_op |=> !alu_flags_r[ST_TO];
endproperty
a_expiry: assert property (p_expiry) else $error("expiry bit not cleared");
property p_sleep;
    sleep_op && !wdt_clear_op |=> !alu_flags_r[ST_PD] && alu_flags_r[ST_TO];
endproperty
a_sleep: assert property (p_sleep) else $error("sleep bits wrong");
property p_borrow;
    sub && alu.a == alu.b && !restore |=> alu_flags_r[ST_C] && alu_flags_r[ST_DC] && alu_flags_r[ST_Z];
endproperty
a_borrow: assert property (p_borrow) else $error("borrow polarity wrong");
property p_ovf;
    ovf |=> stack_overrun_flag_r && soft_reset_r == $past(stack_reset_en);
endproperty
a_ovf: assert property (p_ovf) else $error("overflow not flagged");
property p_restore;
    restore |=> working_reg_r == $past(sh_w_r) && bsr_r == $past(sh_bsr_r);
endproperty
a_restore: assert property (p_restore) else $error("context not restored");

endmodule : core_mem_org

// ---- bench/far_side_model.sv ----
// Program memory and peripheral responder on the far side of the core
`timescale 1ns/1ps
module far_side_model
    import core_mem_pkg::*;
(
    input  wire logic            clk,
    input  wire logic [PC_W-1:0] prog_daddr_r,
    input  wire logic            prog_drd_r,
    input  wire sfr_bus_s        sfr_r,
    output      logic [13:0]     prog_word,
    output      logic [7:0]      sfr_rdata
);
    // ==========================================================
    // Answers
    // Idle lines carry a moving pattern so a mistimed sample is caught
    logic [13:0] junk_r = 14'h0000;
    always_ff @(posedge clk) begin
        junk_r <= junk_r + 14'h1A7;
    end
    assign prog_word = prog_drd_r ? (prog_daddr_r[13:0] ^ 14'h2A5A) : junk_r;
    assign sfr_rdata = (sfr_r.sel && !sfr_r.wr) ? (sfr_r.addr[11:4] ^ {4'hC, sfr_r.addr[3:0]})
                                               : junk_r[7:0];
endmodule : far_side_model

// ---- bench/tb_top.sv ----
// Self-checking testbench for the core memory organisation block
`timescale 1ns/1ps
module tb_top;
    import core_mem_pkg::*;
    // ==========================================================
    // Design and far side
    logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, wdt_clear_op = 1'b0, sleep_op = 1'b0;
    logic wdt_timeout = 1'b0, stack_reset_en = 1'b1, stall_r, drd, he, ov, un, srst;
    logic [1:0] stack_flag_clr = 2'h0;
    data_req_s dreq = '0;
    alu_req_s alu = '0;
    pc_op_e pc_op = PC_HOLD;
    logic [PC_W-1:0] pc_target = '0, pc_r, daddr;
    logic [13:0] prog_word;
    logic [7:0] sfr_rdata, w_r, flags, q;
    data_rsp_s rsp_r;
    sfr_bus_s sfr_r;
    logic seen_stall, seen_sel, seen_drd;
    int fail_count = 0, total_checks = 0, lat;

    always #12.5 clk = ~clk;

    core_mem_org u_core_mem_org (.clk(clk), .rstn(rstn), .ce(ce), .dreq(dreq), .alu(alu),
        .pc_op(pc_op), .pc_target(pc_target), .wdt_clear_op(wdt_clear_op),
        .sleep_op(sleep_op), .wdt_timeout(wdt_timeout), .stack_reset_en(stack_reset_en),
        .stack_flag_clr(stack_flag_clr), .prog_word(prog_word), .sfr_rdata(sfr_rdata),
        .pc_r(pc_r), .rsp_r(rsp_r), .stall_r(stall_r), .working_reg_r(w_r),
        .alu_flags_r(flags), .prog_daddr_r(daddr), .prog_drd_r(drd), .he_region_r(he),
        .sfr_r(sfr_r), .stack_overrun_flag_r(ov), .stack_underrun_flag_r(un),
        .soft_reset_r(srst));
    far_side_model u_far_side_model (.clk(clk), .prog_daddr_r(daddr), .prog_drd_r(drd),
        .sfr_r(sfr_r), .prog_word(prog_word), .sfr_rdata(sfr_rdata));

    // ==========================================================
    // Tasks
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic req(input logic r, input logic w, input src_e s, input logic [6:0] o,
                       input logic [7:0] d);
        @(negedge clk);
        dreq = '{rd: r, wr: w, src: s, ofs: o, wdata: d};
        @(negedge clk);
        dreq.rd = 1'b0;
        dreq.wr = 1'b0;
        seen_stall = stall_r;
        seen_sel = sfr_r.sel;
        seen_drd = drd;
    endtask : req

    task automatic wr(input src_e s, input logic [6:0] o, input logic [7:0] d);
        req(1'b0, 1'b1, s, o, d);
    endtask : wr

    // Slow reads answer one cycle later; the wait is bounded
    task automatic rd(input src_e s, input logic [6:0] o);
        req(1'b1, 1'b0, s, o, 8'h00);
        lat = 0;
        while (rsp_r.valid !== 1'b1 && lat < 4) begin
            @(negedge clk);
            lat++;
        end
        q = rsp_r.rdata;
    endtask : rd

    task automatic pcop(input pc_op_e op, input logic [14:0] t);
        @(negedge clk);
        pc_op = op;
        pc_target = t;
        @(negedge clk);
        pc_op = PC_HOLD;
    endtask : pcop

    task automatic alu_do(input alu_op_e op, input logic [7:0] a, input logic [7:0] b,
                          input logic [7:0] e);
        @(negedge clk);
        alu = '{op: op, a: a, b: b};
        @(negedge clk);
        alu.op = ALU_NONE;
        chk("flags", {8'h00, e}, {8'h00, flags});
    endtask : alu_do

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        #(25 * 4000);
        fail_count++;
        give_verdict();
    end

    // ==========================================================
    // Tests
    initial begin
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        chk("pc", 16'h0000, pc_r);
        chk("flags", 16'h0018, flags);
        wr(SRC_DIRECT, 7'h08, 8'h02);
        rd(SRC_DIRECT, 7'h0C);
        chk("sfr", 16'h00DC, q);
        chk("sfr sel", 16'h0001, seen_sel);
        wr(SRC_DIRECT, 7'h0D, 8'h3C);
        chk("sfr wr sel", 16'h0002, {seen_sel, seen_stall});
        chk("sfr addr", 16'h010D, sfr_r.addr);
        chk("sfr wdata", 16'h013C, {sfr_r.wr, sfr_r.wdata});
        wr(SRC_DIRECT, 7'h70, 8'h77);
        wr(SRC_DIRECT, 7'h08, 8'h05);
        rd(SRC_DIRECT, 7'h70);
        chk("common", 16'h0077, q);
        wr(SRC_DIRECT, 7'h20, 8'h5A);
        rd(SRC_DIRECT, 7'h20);
        chk("ram", 16'h005A, q);
        chk("ram lat", 16'h0000, lat);
        wr(SRC_DIRECT, 7'h08, 8'h14);
        rd(SRC_DIRECT, 7'h20);
        chk("unimpl", 16'h0000, q);
        wr(SRC_DIRECT, 7'h04, 8'h85);
        wr(SRC_DIRECT, 7'h05, 8'hBF);
        rd(SRC_DIRECT, 7'h05);
        chk("ptr0 high", 16'h00BF, q);
        rd(SRC_PTR0, 7'h00);
        chk("prog", 16'h00DF, q);
        chk("prog addr", 16'h1F85, daddr);
        chk("prog lat", 16'h0001, lat);
        chk("stall", 16'h0001, seen_stall);
        chk("he", 16'h0001, he);
        rd(SRC_DIRECT, 7'h00);
        chk("ind0", 16'h00DF, q);
        wr(SRC_PTR0, 7'h00, 8'h11);
        chk("prog wr", 16'h0000, {seen_drd, seen_sel});
        wr(SRC_DIRECT, 7'h06, 8'h55);
        wr(SRC_DIRECT, 7'h07, 8'h20);
        wr(SRC_PTR1, 7'h00, 8'hC3);
        wr(SRC_DIRECT, 7'h08, 8'h01);
        rd(SRC_DIRECT, 7'h25);
        chk("linear", 16'h00C3, q);
        alu_do(ALU_SUB, 8'h05, 8'h05, 8'h1F);
        alu_do(ALU_ADD, 8'hFF, 8'h01, 8'h1F);
        alu_do(ALU_LOGIC, 8'h00, 8'h05, 8'h1B);
        // Flag write and flag-updating operation share one edge
        @(negedge clk);
        dreq = '{rd: 1'b0, wr: 1'b1, src: SRC_DIRECT, ofs: 7'h03, wdata: 8'hFF};
        alu = '{op: ALU_ADD, a: 8'h0F, b: 8'h01};
        @(negedge clk);
        dreq.wr = 1'b0;
        alu.op = ALU_NONE;
        chk("masked", 16'h001A, flags);
        @(negedge clk) sleep_op = 1'b1;
        @(negedge clk) sleep_op = 1'b0;
        chk("sleep", 16'h0012, flags);
        @(negedge clk) wdt_timeout = 1'b1;
        @(negedge clk) wdt_timeout = 1'b0;
        chk("expiry", 16'h0002, flags);
        @(negedge clk) wdt_clear_op = 1'b1;
        @(negedge clk) wdt_clear_op = 1'b0;
        chk("clear", 16'h001A, flags);
        wr(SRC_DIRECT, 7'h03, 8'hE5);
        rd(SRC_DIRECT, 7'h03);
        chk("flags wr", 16'h001D, q);
        pcop(PC_JUMP, 15'h7FFF);
        chk("wrap", 16'h1FFF, pc_r);
        pcop(PC_INC, 15'h0000);
        chk("inc wrap", 16'h0000, pc_r);
        wr(SRC_DIRECT, 7'h0A, 8'h05);
        wr(SRC_DIRECT, 7'h02, 8'h34);
        chk("pcl", 16'h0534, pc_r);
        pcop(PC_JUMP, 15'h0100);
        wr(SRC_DIRECT, 7'h09, 8'h55);
        pcop(PC_INT, 15'h0000);
        chk("int", 16'h0004, pc_r);
        wr(SRC_DIRECT, 7'h09, 8'hAA);
        pcop(PC_RETFIE, 15'h0000);
        chk("shadow", 16'h0055, w_r);
        chk("retfie", 16'h0100, pc_r);
        ce = 1'b0;
        pcop(PC_JUMP, 15'h0333);
        chk("frozen", 16'h0100, pc_r);
        ce = 1'b1;
        repeat (16) pcop(PC_CALL, 15'h0200);
        chk("ov", 16'h0000, ov);
        pcop(PC_CALL, 15'h0200);
        chk("ov", 16'h0001, ov);
        chk("srst", 16'h0001, srst);
        repeat (16) pcop(PC_RET, 15'h0000);
        chk("pop", 16'h0101, pc_r);
        stack_reset_en = 1'b0;
        pcop(PC_RET, 15'h0000);
        chk("un", 16'h8000, {un, pc_r});
        chk("srst off", 16'h0000, srst);
        @(negedge clk) stack_flag_clr = 2'h3;
        @(negedge clk) stack_flag_clr = 2'h0;
        chk("clr", 16'h0000, {ov, un});
        pcop(PC_JUMP, 15'h0123);
        @(negedge clk) rstn = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        chk("rst pc", 16'h0000, pc_r);
        chk("rst flags", 16'h0018, flags);
        give_verdict();
    end
endmodule : tb_top
